/* gwrs_pkg.sv */
// Package: register map, field layout and constants for the wake/RAM block
package gwrs_pkg;
  localparam int GWRS_PINS = 14;
  localparam int GWRS_BANKS = 4;
  localparam logic [11:0] GWRS_ADDR_WAKE_FLAGS = 12'h004;
  localparam logic [11:0] GWRS_ADDR_WAKE_ENABLES = 12'h008;
  localparam logic [11:0] GWRS_ADDR_RAM_OFF = 12'h040;
  localparam logic [11:0] GWRS_ADDR_POWER_MANAGE = 12'h00C;
  localparam logic [11:0] GWRS_ADDR_RETAIN = 12'h010;
  localparam logic [11:0] GWRS_ADDR_IRQ_STATUS = 12'h014;
  localparam logic [11:0] GWRS_ADDR_IRQ_MASK = 12'h018;
  localparam logic [11:0] GWRS_ADDR_MODE = 12'h01C;
  localparam logic [13:0] GWRS_PIN_RESET = 14'h0000;
  localparam logic [3:0] GWRS_BANK_RESET = 4'h0;
  localparam logic [1:0] GWRS_IRQ_RESET = 2'h0;
  localparam int GWRS_IRQ_WAKE = 0;
  localparam int GWRS_IRQ_EDGE = 1;
  localparam int GWRS_GLOBAL_BIT = 0;
  localparam int GWRS_SLEEP_BIT = 0;
endpackage

/* gwrs_top.sv */
// Top: GPIO wakeup flags/enables and RAM bank power shutdown over APB
`timescale 1ns/1ps
module gwrs_top
  import gwrs_pkg::*;
(
  input wire logic sys_clk_i, // System clock, 200 MHz
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [gwrs_pkg::GWRS_PINS-1:0] pins_i, // First pin port levels
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, unmapped address
  output logic [gwrs_pkg::GWRS_BANKS-1:0] bank_power_cut_o, // Bank power off
  output logic [gwrs_pkg::GWRS_BANKS-1:0] bank_backup_retain_o, // Retain
  output logic wake_active_o, // Leave low-power, go ACTIVE
  output logic irq_o // Interrupt, level
);
  import gwrs_pkg::*;

  logic [GWRS_PINS-1:0] pin_sync1, pin_sync2, pin_prev;
  logic [GWRS_PINS-1:0] gpio_wake_flags, gpio_wake_enables;
  logic [GWRS_BANKS-1:0] ram_bank_power_off, bank_retain;
  logic global_pin_wake_enable;
  logic low_power;
  logic [1:0] irq_status, irq_mask;
  logic [GWRS_PINS-1:0] pin_edge;
  logic [GWRS_PINS-1:0] next_flags;
  logic [1:0] next_irq_status;
  logic [31:0] next_rdata;
  logic wake_hit;

  // APB decode: zero wait states, pready high in every access phase
  wire access = psel_i & penable_i;
  wire wr = access & pwrite_i;
  wire hit_flags = paddr_i == GWRS_ADDR_WAKE_FLAGS;
  wire hit_en = paddr_i == GWRS_ADDR_WAKE_ENABLES;
  wire hit_off = paddr_i == GWRS_ADDR_RAM_OFF;
  wire hit_pm = paddr_i == GWRS_ADDR_POWER_MANAGE;
  wire hit_ret = paddr_i == GWRS_ADDR_RETAIN;
  wire hit_ist = paddr_i == GWRS_ADDR_IRQ_STATUS;
  wire hit_imk = paddr_i == GWRS_ADDR_IRQ_MASK;
  wire hit_mode = paddr_i == GWRS_ADDR_MODE;
  wire mapped = hit_flags | hit_en | hit_off | hit_pm | hit_ret | hit_ist
              | hit_imk | hit_mode;

  // Edge on either direction, after a two-stage synchroniser
  assign pin_edge = pin_sync2 ^ pin_prev;

  // Set wins over a simultaneous write-one clear
  assign next_flags = (gpio_wake_flags
                      & ~((wr && hit_flags) ? pwdata_i[GWRS_PINS-1:0]
                                            : GWRS_PIN_RESET))
                      | pin_edge;

  assign wake_hit = global_pin_wake_enable
                    && |(gpio_wake_flags & gpio_wake_enables);

  assign next_irq_status = (irq_status
                           & ~((wr && hit_ist) ? pwdata_i[1:0]
                                               : GWRS_IRQ_RESET))
                           | {|pin_edge, wake_hit & low_power};

  // Upper bits read as zero
  assign next_rdata =
      hit_flags ? {18'h00000, gpio_wake_flags} :
      hit_en ? {18'h00000, gpio_wake_enables} :
      hit_off ? {28'h0000000, ram_bank_power_off} :
      hit_pm ? {31'h00000000, global_pin_wake_enable} :
      hit_ret ? {28'h0000000, bank_retain} :
      hit_ist ? {30'h00000000, irq_status} :
      hit_imk ? {30'h00000000, irq_mask} :
      hit_mode ? {31'h00000000, low_power} : 32'h00000000;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pin_sync1 <= GWRS_PIN_RESET;
      pin_sync2 <= GWRS_PIN_RESET;
      pin_prev <= GWRS_PIN_RESET;
    end else begin
      pin_sync1 <= pins_i;
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2;
    end
  end

  // First sample after reset may flag pins already high; one spurious edge
  // is preferred to missing a real one at release.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      gpio_wake_flags <= GWRS_PIN_RESET;
      irq_status <= GWRS_IRQ_RESET;
    end else begin
      gpio_wake_flags <= next_flags;
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      gpio_wake_enables <= GWRS_PIN_RESET;
      ram_bank_power_off <= GWRS_BANK_RESET;
      bank_retain <= GWRS_BANK_RESET;
      global_pin_wake_enable <= 1'b0;
      irq_mask <= GWRS_IRQ_RESET;
    end else if (wr) begin
      if (hit_en) gpio_wake_enables <= pwdata_i[GWRS_PINS-1:0];
      if (hit_off) ram_bank_power_off <= pwdata_i[GWRS_BANKS-1:0];
      if (hit_ret) bank_retain <= pwdata_i[GWRS_BANKS-1:0];
      if (hit_pm) global_pin_wake_enable <= pwdata_i[GWRS_GLOBAL_BIT];
      if (hit_imk) irq_mask <= pwdata_i[1:0];
    end
  end

  // Low-power state: software enters, a wake returns to ACTIVE (wake wins)
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      low_power <= 1'b0;
    end else if (wake_hit) begin
      low_power <= 1'b0;
    end else if (wr && hit_mode) begin
      low_power <= pwdata_i[GWRS_SLEEP_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      bank_power_cut_o <= GWRS_BANK_RESET;
      bank_backup_retain_o <= GWRS_BANK_RESET;
      wake_active_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      prdata_o <= next_rdata;
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      bank_power_cut_o <= ram_bank_power_off;
      bank_backup_retain_o <= bank_retain;
      wake_active_o <= wake_hit;
      irq_o <= |(next_irq_status & irq_mask);
    end
  end

  property p_edge_sets_flag;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      |pin_edge |=> |gpio_wake_flags;
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag)
    else $error("edge did not set flag");

  property p_zero_write_keeps;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (wr && hit_flags && pwdata_i[13:0] == 14'h0000)
      |=> (gpio_wake_flags & $past(gpio_wake_flags)) == $past(gpio_wake_flags);
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps)
    else $error("zero write cleared a flag");

  property p_wake_returns;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      wake_hit |=> !low_power ##0 wake_active_o;
  endproperty
  a_wake_returns: assert property (p_wake_returns)
    else $error("wake did not return to active");

  property p_enable_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (wr && hit_en) |=> gpio_wake_enables == $past(pwdata_i[13:0]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write lost");

  property p_no_wake_global_off;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !global_pin_wake_enable |=> !wake_active_o;
  endproperty
  a_no_wake_global_off: assert property (p_no_wake_global_off)
    else $error("wake without global enable");

  property p_upper_zero;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (access && (hit_flags || hit_en)) |=> prdata_o[31:14] == 18'h00000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper bits not zero");

  property p_cut_follows;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (wr && hit_off) |=> ##1 bank_power_cut_o == $past(pwdata_i[3:0], 2);
  endproperty
  a_cut_follows: assert property (p_cut_follows)
    else $error("bank cut output wrong");

  property p_reserved_ro;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (access && hit_off) |=> prdata_o[31:4] == 28'h0000000;
  endproperty
  a_reserved_ro: assert property (p_reserved_ro)
    else $error("reserved bits not zero");

  property p_clear_on_one;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (wr && hit_flags && pin_edge == GWRS_PIN_RESET)
      |=> (gpio_wake_flags & $past(pwdata_i[GWRS_PINS-1:0]))
          == GWRS_PIN_RESET;
  endproperty
  a_clear_on_one: assert property (p_clear_on_one)
    else $error("written one did not clear flag");

  property p_flag_sticky;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !(wr && hit_flags)
      |=> (gpio_wake_flags & $past(gpio_wake_flags)) == $past(gpio_wake_flags);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag cleared without a write");

  property p_no_edge_no_set;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      pin_edge == GWRS_PIN_RESET
      |=> (gpio_wake_flags & ~$past(gpio_wake_flags)) == GWRS_PIN_RESET;
  endproperty
  a_no_edge_no_set: assert property (p_no_edge_no_set)
    else $error("flag set without an edge");

  property p_rise_sets_flag;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      |(pin_sync2 & ~pin_prev)
      |=> (gpio_wake_flags & $past(pin_sync2 & ~pin_prev))
          == $past(pin_sync2 & ~pin_prev);
  endproperty
  a_rise_sets_flag: assert property (p_rise_sets_flag)
    else $error("rising edge did not set its flag");

  property p_fall_sets_flag;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      |(pin_prev & ~pin_sync2)
      |=> (gpio_wake_flags & $past(pin_prev & ~pin_sync2))
          == $past(pin_prev & ~pin_sync2);
  endproperty
  a_fall_sets_flag: assert property (p_fall_sets_flag)
    else $error("falling edge did not set its flag");

  property p_reset_values;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $rose(nrst_i)
      |-> gpio_wake_flags == GWRS_PIN_RESET
          && gpio_wake_enables == GWRS_PIN_RESET
          && bank_power_cut_o == GWRS_BANK_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("field not zero after reset");

  property p_wake_needs_match;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (gpio_wake_flags & gpio_wake_enables) == GWRS_PIN_RESET
      |=> !wake_active_o;
  endproperty
  a_wake_needs_match: assert property (p_wake_needs_match)
    else $error("wake without an enabled flag");

  property p_sleep_ends;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (low_power && wake_hit)
      |=> !low_power && irq_status[GWRS_IRQ_WAKE];
  endproperty
  a_sleep_ends: assert property (p_sleep_ends)
    else $error("wake did not leave low power");

  property p_retain_follows;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (wr && hit_ret)
      |=> ##1 bank_backup_retain_o == $past(pwdata_i[GWRS_BANKS-1:0], 2);
  endproperty
  a_retain_follows: assert property (p_retain_follows)
    else $error("retain output wrong");

  property p_cut_keeps_retain;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (wr && hit_off) |=> bank_retain == $past(bank_retain);
  endproperty
  a_cut_keeps_retain: assert property (p_cut_keeps_retain)
    else $error("cut write changed retain bits");

  property p_ready_pulse;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready stood longer than one cycle");

  property p_unmapped_err;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (psel_i && !penable_i && !mapped) |=> pready_o && pslverr_o;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access without error");

  property p_irq_masked;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      irq_mask == GWRS_IRQ_RESET |=> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt with all sources masked");
endmodule // gwrs_top

/* tb_gwrs.sv */
// Testbench: APB registers, pin wake flags, wake, irq and RAM bank power
`timescale 1ns/1ps
module tb;
  import gwrs_pkg::*;
  logic sys_clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic [13:0] pins_i = '0, r;
  logic pready_o, pslverr_o, wake_active_o, irq_o;
  logic [3:0] bank_power_cut_o, bank_backup_retain_o;
  logic [33:0] notes[$], note;
  int mismatches = 0, checks = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  gwrs_top uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pins_i(pins_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .bank_power_cut_o(bank_power_cut_o),
    .bank_backup_retain_o(bank_backup_retain_o),
    .wake_active_o(wake_active_o), .irq_o(irq_o));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Note layout: bit 33 read, bit 32 error expected, 31:0 read data
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    @(posedge sys_clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    notes.push_back({~w, e});
    @(posedge sys_clk_i);
    penable_i <= 1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      check("pready_o", {31'h0, pready_o}, 32'h1);
      give_verdict();
    end
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] d, input logic err = 0);
    apb(1'b0, a, 32'h0, {err, d});
  endtask
  task settle_check(input string nm, input logic [31:0] seen_now,
    input logic [31:0] exp);
    check(nm, seen_now, exp);
  endtask
  // Response watcher: oldest note against each answer
  always @(posedge sys_clk_i) begin
    if (nrst_i && pready_o === 1'b1) begin
      if (notes.size() == 0) check("unrequested ready", 32'h1, 32'h0);
      else begin
        note = notes.pop_front();
        check("pslverr", {31'h0, pslverr_o}, {31'h0, note[32]});
        if (note[33]) check("prdata", prdata_o, note[31:0]);
      end
    end
  end
  initial begin
    void'($urandom(34));
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1;
    rd(GWRS_ADDR_WAKE_FLAGS, 32'h0);
    rd(GWRS_ADDR_WAKE_ENABLES, 32'h0);
    rd(GWRS_ADDR_RAM_OFF, 32'h0);
    rd(12'h100, 32'h0, 1'b1);
    wr(GWRS_ADDR_WAKE_ENABLES, 32'hFFFFFFFF);
    rd(GWRS_ADDR_WAKE_ENABLES, 32'h00003FFF);
    wr(GWRS_ADDR_RAM_OFF, 32'hFFFFFFF9);
    rd(GWRS_ADDR_RAM_OFF, 32'h00000009);
    check("bank_power_cut_o", {28'h0, bank_power_cut_o}, 32'h9);
    // Random rising edges, then falling edges on the same pins
    r = 14'($urandom) | 14'h0001;
    pins_i <= r;
    repeat (5) @(posedge sys_clk_i);
    rd(GWRS_ADDR_WAKE_FLAGS, {18'h0, r});
    check("irq_o", {31'h0, irq_o}, 32'h0);
    wr(GWRS_ADDR_IRQ_MASK, 32'h2);
    repeat (3) @(posedge sys_clk_i);
    check("irq_o", {31'h0, irq_o}, 32'h1);
    wr(GWRS_ADDR_WAKE_FLAGS, 32'h0);
    rd(GWRS_ADDR_WAKE_FLAGS, {18'h0, r});
    wr(GWRS_ADDR_WAKE_FLAGS, 32'hFFFFFFFF);
    rd(GWRS_ADDR_WAKE_FLAGS, 32'h0);
    pins_i <= '0;
    repeat (5) @(posedge sys_clk_i);
    rd(GWRS_ADDR_WAKE_FLAGS, {18'h0, r});
    check("wake_active_o", {31'h0, wake_active_o}, 32'h0);
    wr(GWRS_ADDR_WAKE_ENABLES, {18'h0, ~r});
    wr(GWRS_ADDR_POWER_MANAGE, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    check("wake_active_o", {31'h0, wake_active_o}, 32'h0);
    wr(GWRS_ADDR_WAKE_ENABLES, {18'h0, r});
    repeat (3) @(posedge sys_clk_i);
    check("wake_active_o", {31'h0, wake_active_o}, 32'h1);
    wr(GWRS_ADDR_WAKE_FLAGS, 32'hFFFFFFFF);
    wr(GWRS_ADDR_IRQ_STATUS, 32'h2);
    repeat (3) @(posedge sys_clk_i);
    check("wake_active_o", {31'h0, wake_active_o}, 32'h0);
    check("irq_o", {31'h0, irq_o}, 32'h0);
    // Low-power entry, then rising edges on enabled pins wake it
    wr(GWRS_ADDR_MODE, 32'h1);
    rd(GWRS_ADDR_MODE, 32'h1);
    rd(GWRS_ADDR_POWER_MANAGE, 32'h1);
    wr(GWRS_ADDR_IRQ_MASK, 32'h3);
    pins_i <= r;
    repeat (5) @(posedge sys_clk_i);
    rd(GWRS_ADDR_MODE, 32'h0);
    rd(GWRS_ADDR_IRQ_STATUS, 32'h3);
    check("wake_active_o", {31'h0, wake_active_o}, 32'h1);
    check("irq_o", {31'h0, irq_o}, 32'h1);
    wr(GWRS_ADDR_RETAIN, 32'hFFFFFFF5);
    rd(GWRS_ADDR_RETAIN, 32'h00000005);
    check("bank_backup_retain_o", {28'h0, bank_backup_retain_o}, 32'h5);
    check("bank_power_cut_o", {28'h0, bank_power_cut_o}, 32'h9);
    apb(1'b1, 12'h100, 32'hFFFFFFFF, {1'b1, 32'h0});
    rd(GWRS_ADDR_RAM_OFF, 32'h00000009);
    // Pins low first, so no edge is seen against the reset value
    pins_i <= '0;
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1;
    rd(GWRS_ADDR_WAKE_FLAGS, 32'h0);
    rd(GWRS_ADDR_WAKE_ENABLES, 32'h0);
    rd(GWRS_ADDR_RAM_OFF, 32'h0);
    check("bank_power_cut_o", {28'h0, bank_power_cut_o}, 32'h0);
    check("wake_active_o", {31'h0, wake_active_o}, 32'h0);
    check("irq_o", {31'h0, irq_o}, 32'h0);
    give_verdict();
  end
endmodule // tb
